//--- logic/epmux_defines.svh
// register map, field positions and reset values of the pin mux
// assumes a 16-bit register port with a 4-bit word index
`ifndef EPMUX_DEFINES_SVH
`define EPMUX_DEFINES_SVH

`define EPMUX_DW        16
`define EPMUX_AW        4

// word indices
`define EPMUX_IDX_BUS_CTRL  4'h0
`define EPMUX_IDX_PB_PER    4'h1
`define EPMUX_IDX_PB_DDR    4'h2
`define EPMUX_IDX_PB_DR     4'h3
`define EPMUX_IDX_PB_PUR    4'h4
`define EPMUX_IDX_PF_PER    4'h5
`define EPMUX_IDX_PF_DDR    4'h6
`define EPMUX_IDX_PF_DR     4'h7
`define EPMUX_IDX_PF_PUR    4'h8
`define EPMUX_IDX_PB_PIN    4'h9
`define EPMUX_IDX_PF_PIN    4'hA
`define EPMUX_IDX_STATUS    4'hB

// field positions
`define EPMUX_HOLD_BIT      0
`define EPMUX_PB_BIT        0
`define EPMUX_PF_LSB        9
`define EPMUX_PF_MSB        15
`define EPMUX_ST_BOOT_BIT   0
`define EPMUX_ST_ACT_BIT    1

// reset values
`define EPMUX_RST_HOLD      1'b0
`define EPMUX_RST_PB_DDR    1'b0
`define EPMUX_RST_PB_DR     1'b0
`define EPMUX_RST_PB_PUR    1'b1
`define EPMUX_RST_PF_PER    7'h7F
`define EPMUX_RST_PF_DDR    7'h00
`define EPMUX_RST_PF_DR     7'h00
`define EPMUX_RST_PF_PUR    7'h7F
`define EPMUX_ZERO          16'h0000

`endif

//--- logic/epmux_pad_cell.sv
// one shared pad: function select, idle tri-state, pull-up, input sync
// assumes all select inputs come from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none

module epmux_pad_cell (
	input  wire logic sys_clk,     // system clock
	input  wire logic rst_b,       // sync reset, active low
	input  wire logic bus_mode,    // 1: memory interface owns pad
	input  wire logic gpio_dir,    // 1: gpio output
	input  wire logic gpio_dout,   // gpio data register bit
	input  wire logic bus_out,     // memory interface level
	input  wire logic bus_oe_req,  // memory interface wants to drive
	input  wire logic pullup_en,   // pull-up enable bit
	input  wire logic pad_in,      // pad level from outside
	output logic      pad_out,     // pad output level
	output logic      pad_oe,      // pad output enable, high drives
	output logic      pad_pu,      // pull-up on
	output logic      pin_level    // synchronised pad level
);
	logic out_next;
	logic oe_next;
	logic sync1_reg;
	logic sync2_reg;

	// function select; bus side decides its own enable
	assign out_next = bus_mode ? bus_out : gpio_dout;
	assign oe_next  = bus_mode ? bus_oe_req : gpio_dir;

	// registered pad drive; reset leaves pad an input with pull-up
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pad_out <= 1'b0;
			pad_oe  <= 1'b0;
			pad_pu  <= 1'b1;
		end else begin
			pad_out <= out_next;
			pad_oe  <= oe_next;
			pad_pu  <= pullup_en;
		end
	end

	// three-stage sync, no reset so the chain is settled at release
	always_ff @(posedge sys_clk) begin
		sync1_reg <= pad_in;
		sync2_reg <= sync1_reg;
		pin_level <= sync2_reg;
	end
endmodule

`default_nettype wire

//--- logic/epmux_pkg.sv
// types shared by the pin mux files
// assumes epmux_defines.svh is on the include path
`include "epmux_defines.svh"

package epmux_pkg;
	typedef logic [`EPMUX_AW-1:0] epmux_addr_t;
	typedef logic [`EPMUX_DW-1:0] epmux_data_t;
	typedef enum logic [1:0] {
		EPMUX_BOOT_HOLD,
		EPMUX_BOOT_LOAD,
		EPMUX_RUN
	} epmux_boot_t;
endpackage

//--- logic/epmux_top.sv
// pin mux for the top address pin and seven low data pins
// assumes memory interface and register master run on sys_clk;
// strap inputs come from pins and are synchronised here
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "epmux_defines.svh"

// Notes on behaviour
// - port b pin zero: software gpio in or out
// - idle bus tri-states address pin unless hold
// - reset picks pin zero function from straps
// - port b enable write overrides boot choice
// - clearing port b pull-up bit 0 disables it
// - idle bus tri-states data pins unless hold
// - port f pins 9..15 individually gpio programmable
// - port f pins default to data bus
// - port f pull-up bit per pin disables it
module epmux_top #(
	parameter int NUM_DATA = 7     // shared low data pins
) (
	input  wire logic               sys_clk,      // 20 MHz system clock
	input  wire logic               rst_b,        // sync reset, active low
	input  wire epmux_pkg::epmux_addr_t reg_addr, // register word index
	input  wire epmux_pkg::epmux_data_t reg_wdata,// write data
	input  wire logic               reg_wr,       // write strobe
	input  wire logic               reg_rd,       // read strobe
	output epmux_pkg::epmux_data_t  reg_rdata,    // read data, next cycle
	input  wire logic               external_boot_select, // strap pin
	input  wire logic               ext_mem_mode_select,  // strap pin
	input  wire logic               flash_secured,        // security pin
	input  wire logic               bus_active,   // memory cycle running
	input  wire logic               address_line_top,     // top address
	input  wire logic [NUM_DATA-1:0] data_lines_low_out,  // write data
	input  wire logic               data_drive,   // interface drives data
	output logic [NUM_DATA-1:0]     data_lines_low_in,    // synced data
	input  wire logic [NUM_DATA:0]  pad_in,       // pad levels, 0 = b0
	output logic [NUM_DATA:0]       pad_out,      // pad output levels
	output logic [NUM_DATA:0]       pad_oe,       // pad output enables
	output logic [NUM_DATA:0]       pad_pu        // pad pull-up enables
);
	import epmux_pkg::*;

	if (NUM_DATA != `EPMUX_PF_MSB - `EPMUX_PF_LSB + 1) begin : g_width_check
		$error("NUM_DATA must match port f field");
	end

	localparam int NP = NUM_DATA + 1;

	// control registers
	logic                bus_drive_hold_reg;
	logic                port_b_periph_enable_reg;
	logic                pb_ddr_reg;
	logic                pb_dr_reg;
	logic                port_b_pullup_enable_reg;
	logic [NUM_DATA-1:0] pf_per_reg;
	logic [NUM_DATA-1:0] pf_ddr_reg;
	logic [NUM_DATA-1:0] pf_dr_reg;
	logic [NUM_DATA-1:0] port_f_pullup_enable_reg;
	logic                boot_addr_reg;
	epmux_boot_t         boot_reg;
	epmux_boot_t         boot_next;

	// strap synchronisers
	logic [2:0] strap_s1_reg;
	logic [2:0] strap_s2_reg;

	// per-pad vectors
	logic [NP-1:0] pin_bus;
	logic [NP-1:0] pin_dir;
	logic [NP-1:0] pin_dout;
	logic [NP-1:0] pin_bout;
	logic [NP-1:0] pin_boe;
	logic [NP-1:0] pin_pue;
	logic [NP-1:0] pin_lvl;

	// address decode
	wire wr_hold = reg_wr && (reg_addr == `EPMUX_IDX_BUS_CTRL);
	wire wr_pbpe = reg_wr && (reg_addr == `EPMUX_IDX_PB_PER);
	wire wr_pbdd = reg_wr && (reg_addr == `EPMUX_IDX_PB_DDR);
	wire wr_pbdr = reg_wr && (reg_addr == `EPMUX_IDX_PB_DR);
	wire wr_pbpu = reg_wr && (reg_addr == `EPMUX_IDX_PB_PUR);
	wire wr_pfpe = reg_wr && (reg_addr == `EPMUX_IDX_PF_PER);
	wire wr_pfdd = reg_wr && (reg_addr == `EPMUX_IDX_PF_DDR);
	wire wr_pfdr = reg_wr && (reg_addr == `EPMUX_IDX_PF_DR);
	wire wr_pfpu = reg_wr && (reg_addr == `EPMUX_IDX_PF_PUR);

	wire                wb = reg_wdata[`EPMUX_PB_BIT];
	wire [NUM_DATA-1:0] wf = reg_wdata[`EPMUX_PF_MSB:`EPMUX_PF_LSB];

	// boot choice: mode strap, or external boot on an open part
	wire boot_addr_sel = strap_s2_reg[1]
		| (strap_s2_reg[0] & ~strap_s2_reg[2]);

	// bus-mode enables: address idles driven only under hold
	wire addr_oe = bus_active | bus_drive_hold_reg;
	wire data_oe = data_drive & (bus_active | bus_drive_hold_reg);

	// straps are pins: two flops before any use
	always_ff @(posedge sys_clk) begin
		strap_s1_reg <= {flash_secured, ext_mem_mode_select,
			external_boot_select};
		strap_s2_reg <= strap_s1_reg;
	end

	// boot sequencer: wait one cycle after release, then load
	always_comb begin
		boot_next = boot_reg;
		unique case (boot_reg)
			EPMUX_BOOT_HOLD: boot_next = EPMUX_BOOT_LOAD;
			EPMUX_BOOT_LOAD: boot_next = EPMUX_RUN;
			EPMUX_RUN:       boot_next = EPMUX_RUN;
			default:         boot_next = EPMUX_BOOT_HOLD;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			boot_reg <= EPMUX_BOOT_HOLD;
		else
			boot_reg <= boot_next;
	end

	// port b enable: gpio during reset, boot loads, software wins
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port_b_periph_enable_reg <= 1'b0;
			boot_addr_reg <= 1'b0;
		end else begin
			if (boot_reg == EPMUX_BOOT_LOAD) boot_addr_reg <= boot_addr_sel;
			if (wr_pbpe)
				port_b_periph_enable_reg <= wb;
			else if (boot_reg == EPMUX_BOOT_LOAD)
				port_b_periph_enable_reg <= boot_addr_sel;
		end
	end

	// port b gpio and pull-up bits
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pb_ddr_reg <= `EPMUX_RST_PB_DDR;
			pb_dr_reg <= `EPMUX_RST_PB_DR;
			port_b_pullup_enable_reg <= `EPMUX_RST_PB_PUR;
		end else begin
			if (wr_pbdd) pb_ddr_reg <= wb;
			if (wr_pbdr) pb_dr_reg <= wb;
			if (wr_pbpu) port_b_pullup_enable_reg <= wb;
		end
	end

	// port f bits; each pin owns its own bit
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pf_per_reg <= `EPMUX_RST_PF_PER;
			pf_ddr_reg <= `EPMUX_RST_PF_DDR;
			pf_dr_reg <= `EPMUX_RST_PF_DR;
			port_f_pullup_enable_reg <= `EPMUX_RST_PF_PUR;
		end else begin
			if (wr_pfpe) pf_per_reg <= wf;
			if (wr_pfdd) pf_ddr_reg <= wf;
			if (wr_pfdr) pf_dr_reg <= wf;
			if (wr_pfpu) port_f_pullup_enable_reg <= wf;
		end
	end

	// the default leaves the bus idle-floating; software should set it
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			bus_drive_hold_reg <= `EPMUX_RST_HOLD;
		else if (wr_hold)
			bus_drive_hold_reg <= reg_wdata[`EPMUX_HOLD_BIT];
	end

	// pad 0 is the shared top address pin
	assign pin_bus[0]  = port_b_periph_enable_reg;
	assign pin_dir[0]  = pb_ddr_reg;
	assign pin_dout[0] = pb_dr_reg;
	assign pin_bout[0] = address_line_top;
	assign pin_boe[0]  = addr_oe;
	assign pin_pue[0]  = port_b_pullup_enable_reg;

	// pads 1..7 are the shared data pins
	assign pin_bus[NP-1:1]  = pf_per_reg;
	assign pin_dir[NP-1:1]  = pf_ddr_reg;
	assign pin_dout[NP-1:1] = pf_dr_reg;
	assign pin_bout[NP-1:1] = data_lines_low_out;
	assign pin_boe[NP-1:1]  = {NUM_DATA{data_oe}};
	assign pin_pue[NP-1:1]  = port_f_pullup_enable_reg;

	// one pad cell per shared pin
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_pad
			epmux_pad_cell u_pad (
				.sys_clk    (sys_clk),
				.rst_b      (rst_b),
				.bus_mode   (pin_bus[gi]),
				.gpio_dir   (pin_dir[gi]),
				.gpio_dout  (pin_dout[gi]),
				.bus_out    (pin_bout[gi]),
				.bus_oe_req (pin_boe[gi]),
				.pullup_en  (pin_pue[gi]),
				.pad_in     (pad_in[gi]),
				.pad_out    (pad_out[gi]),
				.pad_oe     (pad_oe[gi]),
				.pad_pu     (pad_pu[gi]),
				.pin_level  (pin_lvl[gi])
			);
		end
	endgenerate

	assign data_lines_low_in = pin_lvl[NP-1:1];

	// read mux; unmapped words read zero
	epmux_data_t rd_mux;
	always_comb begin
		rd_mux = `EPMUX_ZERO;
		unique case (reg_addr)
			`EPMUX_IDX_BUS_CTRL:
				rd_mux[`EPMUX_HOLD_BIT] = bus_drive_hold_reg;
			`EPMUX_IDX_PB_PER:
				rd_mux[`EPMUX_PB_BIT] = port_b_periph_enable_reg;
			`EPMUX_IDX_PB_DDR: rd_mux[`EPMUX_PB_BIT] = pb_ddr_reg;
			`EPMUX_IDX_PB_DR:  rd_mux[`EPMUX_PB_BIT] = pb_dr_reg;
			`EPMUX_IDX_PB_PUR:
				rd_mux[`EPMUX_PB_BIT] = port_b_pullup_enable_reg;
			`EPMUX_IDX_PF_PER:
				rd_mux[`EPMUX_PF_MSB:`EPMUX_PF_LSB] = pf_per_reg;
			`EPMUX_IDX_PF_DDR:
				rd_mux[`EPMUX_PF_MSB:`EPMUX_PF_LSB] = pf_ddr_reg;
			`EPMUX_IDX_PF_DR:
				rd_mux[`EPMUX_PF_MSB:`EPMUX_PF_LSB] = pf_dr_reg;
			`EPMUX_IDX_PF_PUR:
				rd_mux[`EPMUX_PF_MSB:`EPMUX_PF_LSB] = port_f_pullup_enable_reg;
			`EPMUX_IDX_PB_PIN: rd_mux[`EPMUX_PB_BIT] = pin_lvl[0];
			`EPMUX_IDX_PF_PIN:
				rd_mux[`EPMUX_PF_MSB:`EPMUX_PF_LSB] = pin_lvl[NP-1:1];
			`EPMUX_IDX_STATUS: begin
				rd_mux[`EPMUX_ST_BOOT_BIT] = boot_addr_reg;
				rd_mux[`EPMUX_ST_ACT_BIT] = bus_active;
			end
			default: rd_mux = `EPMUX_ZERO;
		endcase
	end

	// read data stands exactly one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			reg_rdata <= `EPMUX_ZERO;
		else
			reg_rdata <= reg_rd ? rd_mux : `EPMUX_ZERO;
	end

	// gpio pad drive follows direction and data one cycle later
	property p_b0_gpio;
		@(posedge sys_clk) disable iff (!rst_b)
		!port_b_periph_enable_reg |=>
			(pad_oe[0] == $past(pb_ddr_reg)) && (pad_out[0] == $past(pb_dr_reg));
	endproperty
	a_b0_gpio: assert property (p_b0_gpio)
		else $error("port b pin zero gpio drive mismatch");

	property p_addr_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		(port_b_periph_enable_reg && !bus_drive_hold_reg && !bus_active) |=> !pad_oe[0];
	endproperty
	a_addr_idle: assert property (p_addr_idle)
		else $error("address pin driven on idle bus");

	property p_boot_load;
		@(posedge sys_clk) disable iff (!rst_b)
		(boot_reg == EPMUX_BOOT_LOAD && !wr_pbpe) |=>
			port_b_periph_enable_reg == $past(boot_addr_sel);
	endproperty
	a_boot_load: assert property (p_boot_load)
		else $error("boot function not loaded");

	property p_pb_write;
		@(posedge sys_clk) disable iff (!rst_b)
		wr_pbpe |=> port_b_periph_enable_reg == $past(reg_wdata[`EPMUX_PB_BIT]);
	endproperty
	a_pb_write: assert property (p_pb_write)
		else $error("port b enable write lost");

	property p_pb_pull;
		@(posedge sys_clk) disable iff (!rst_b)
		(wr_pbpu && !wb) |=> ##1 !pad_pu[0];
	endproperty
	a_pb_pull: assert property (p_pb_pull)
		else $error("port b pull-up stayed on");

	property p_data_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		(pf_per_reg[0] && !bus_drive_hold_reg && !bus_active) |=> !pad_oe[1];
	endproperty
	a_data_idle: assert property (p_data_idle)
		else $error("data pin driven on idle bus");

	property p_pf_dir;
		@(posedge sys_clk) disable iff (!rst_b)
		wr_pfdd |=> pf_ddr_reg == $past(wf);
	endproperty
	a_pf_dir: assert property (p_pf_dir)
		else $error("port f direction write lost");

	property p_pf_default;
		@(posedge sys_clk) disable iff (!rst_b)
		$rose(rst_b) |-> pf_per_reg == `EPMUX_RST_PF_PER;
	endproperty
	a_pf_default: assert property (p_pf_default)
		else $error("port f not bus after reset");

	property p_pf_pull;
		@(posedge sys_clk) disable iff (!rst_b)
		!port_f_pullup_enable_reg[0] |=> !pad_pu[1];
	endproperty
	a_pf_pull: assert property (p_pf_pull)
		else $error("port f pull-up stayed on");

	property p_addr_bus;
		@(posedge sys_clk) disable iff (!rst_b)
		(port_b_periph_enable_reg && addr_oe) |=>
			pad_oe[0] && (pad_out[0] == $past(address_line_top));
	endproperty
	a_addr_bus: assert property (p_addr_bus)
		else $error("address pin not following interface");

	property p_reset_safe;
		@(posedge sys_clk)
		!rst_b |=> (pad_oe == '0) && (pad_pu == '1);
	endproperty
	a_reset_safe: assert property (p_reset_safe)
		else $error("pads not safe during reset");
endmodule

`default_nettype wire

//--- sim/epmux_mem_model.sv
// far side of the shared pads: external memory plus a board driver
// assumes pad_oe high means the device drives the pad
`timescale 1ns/1ps
`default_nettype none

module epmux_mem_model (
	input  wire logic [7:0] pad_out,  // device levels
	input  wire logic [7:0] pad_oe,   // device enables
	input  wire logic [7:0] pad_pu,   // device pull-ups
	input  wire logic       sys_clk,  // system clock
	input  wire logic [7:0] ext_en,   // far side drives pad
	input  wire logic [7:0] ext_val,  // far side level
	output logic [7:0]      pad_in    // resolved pad levels
);
	logic flip_reg;

	// a floating pad wanders every cycle, so no stale level passes
	initial flip_reg = 1'b0;
	always @(posedge sys_clk) begin
		flip_reg <= ~flip_reg;
	end

	// device first, then memory or board, then pull-up, else noise
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pad_pu[i]) begin
				pad_in[i] = 1'b1;
			end else begin
				pad_in[i] = flip_reg ^ i[0];
			end
		end
	end
endmodule

`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the external bus pin mux
// assumes the register map header and package of the design
`timescale 1ns/1ps
`default_nettype none
`include "epmux_defines.svh"

module tb_top;
	import epmux_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	epmux_addr_t reg_addr = '0;
	epmux_data_t reg_wdata = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	epmux_data_t reg_rdata;
	logic        boot = 1'b1;
	logic        mode = 1'b0;
	logic        sec = 1'b0;
	logic        bus_active = 1'b0;
	logic        addr_top = 1'b1;
	logic [6:0]  dout = 7'h55;
	logic        data_drive = 1'b1;
	logic [6:0]  din;
	logic [7:0]  pad_in, pad_out, pad_oe, pad_pu;
	logic [7:0]  ext_en = 8'h00;
	logic [7:0]  ext_val = 8'h00;
	int          num_errors = 0;
	int          n_compared = 0;

	epmux_top #(.NUM_DATA(7)) u_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .external_boot_select(boot),
		.ext_mem_mode_select(mode), .flash_secured(sec),
		.bus_active(bus_active), .address_line_top(addr_top),
		.data_lines_low_out(dout), .data_drive(data_drive),
		.data_lines_low_in(din), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pu(pad_pu));

	epmux_mem_model u_mem (
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
		.sys_clk(sys_clk), .ext_en(ext_en), .ext_val(ext_val),
		.pad_in(pad_in));

	// 20 MHz system clock
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one-cycle strobes, a cycle apart, so no signal is set twice at one edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 check(name, reg_rdata, exp);
	endtask

	// pads follow a register one edge after the strobe edge
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic do_reset(input logic b, input logic m, input logic s);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		boot <= b;
		mode <= m;
		sec <= s;
		repeat (2) @(posedge sys_clk);
		#1 check("oe in reset", {8'h00, pad_oe}, 16'h0000);
		check("pu in reset", {8'h00, pad_pu}, 16'h00FF);
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic test_bus;
		settle;
		check("oe idle", {8'h00, pad_oe}, 16'h0000);
		@(posedge sys_clk);
		bus_active <= 1'b1;
		settle;
		check("oe busy", {8'h00, pad_oe}, 16'h00FF);
		check("out busy", {8'h00, pad_out}, 16'h00AB);
		rd(`EPMUX_IDX_STATUS, 16'h0003, "status busy");
		@(posedge sys_clk);
		bus_active <= 1'b0;
		wr(`EPMUX_IDX_BUS_CTRL, 16'h0001);
		rd(`EPMUX_IDX_BUS_CTRL, 16'h0001, "hold read");
		settle;
		check("oe hold", {8'h00, pad_oe}, 16'h00FF);
		// memory read: device lets go of data, memory drives it
		@(posedge sys_clk);
		data_drive <= 1'b0;
		ext_en <= 8'hFE;
		ext_val <= 8'h4C;
		settle;
		check("oe read", {8'h00, pad_oe}, 16'h0001);
		repeat (4) @(posedge sys_clk);
		#1 check("data in", {9'h000, din}, 16'h0026);
		ext_en <= 8'h00;
		$display("test bus done");
	endtask

	task automatic test_gpio;
		wr(`EPMUX_IDX_PB_PER, 16'h0000);
		wr(`EPMUX_IDX_PB_DDR, 16'h0001);
		wr(`EPMUX_IDX_PB_DR, 16'h0001);
		wr(`EPMUX_IDX_PF_PER, 16'h0000);
		wr(`EPMUX_IDX_PF_DDR, 16'hAA00);
		wr(`EPMUX_IDX_PF_DR, 16'hFE00);
		settle;
		check("oe gpio", {8'h00, pad_oe}, 16'h00AB);
		check("out gpio", {8'h00, pad_out}, 16'h00FF);
		wr(`EPMUX_IDX_PB_DDR, 16'h0000);
		ext_en <= 8'h01;
		ext_val <= 8'h00;
		repeat (5) @(posedge sys_clk);
		rd(`EPMUX_IDX_PB_PIN, 16'h0000, "pin zero in");
		rd(`EPMUX_IDX_PF_PIN, 16'hFE00, "port f in");
		ext_en <= 8'h00;
		$display("test gpio done");
	endtask

	task automatic test_pullup;
		logic [6:0] exp;
		wr(`EPMUX_IDX_PB_PUR, 16'h0000);
		settle;
		check("pu pin zero", {15'h0000, pad_pu[0]}, 16'h0000);
		for (int k = 0; k < 7; k++) begin
			exp = 7'h7F ^ (7'h01 << k);
			wr(`EPMUX_IDX_PF_PUR, {exp, 9'h000});
			settle;
			check("pu port f", {8'h00, pad_pu}, {8'h00, exp, 1'b0});
		end
		$display("test pullup done");
	endtask

	// every strap combination picks pin zero function at reset
	task automatic test_straps;
		logic e;
		for (int i = 0; i < 8; i++) begin
			e = i[1] | (i[0] & ~i[2]);
			do_reset(i[0], i[1], i[2]);
			rd(`EPMUX_IDX_PB_PER, {15'h0000, e}, "boot pick");
			rd(`EPMUX_IDX_STATUS, {15'h0000, e}, "boot status");
			rd(`EPMUX_IDX_PF_PER, 16'hFE00, "port f default");
		end
		rd(4'hC, 16'h0000, "unmapped");
		@(posedge sys_clk);
		#1 check("rdata after", reg_rdata, 16'h0000);
		$display("test straps done");
	endtask

	// bound on the whole run
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		finish_test();
	end

	initial begin
		do_reset(1'b1, 1'b0, 1'b0);
		test_bus();
		test_gpio();
		test_pullup();
		test_straps();
		finish_test();
	end
endmodule

`default_nettype wire
